// >>> hdl/ocol_cmd_core.sv
// Serial word-command slave for current offset calibration and OV fault limit
`timescale 1ns/1ns
`include "ocol_consts.svh"
module ocol_cmd_core
  import ocol_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h4C,
  parameter int NPH = 4,
  parameter logic [7:0] PH_PAGE1 = 8'h0C,
  parameter int CLK_MHZ = 20,
  parameter int HICCUP_US = `OCOL_HICCUP_US,
  parameter int HICCUP_CYC = HICCUP_US * CLK_MHZ
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic [7:0] i_page,
  input wire logic [7:0] i_phase,
  input wire logic [1:0][15:0] i_vout_cmd,
  input wire logic [1:0] i_boot_zero,
  input wire logic [NPH-1:0] i_ph_active,
  input wire logic i_nvm_store,
  input wire logic i_nvm_restore,
  input wire logic [NPH-1:0][5:0] i_nvm_off_code,
  input wire logic [1:0][3:0] i_nvm_ov_step,
  input wire logic [1:0] i_ov_detect,
  input wire ocol_ov_cfg_s [1:0] i_ov_cfg,
  input wire logic i_clear_faults,
  input wire logic [1:0] i_off_cmd,
  output logic [NPH-1:0][5:0] o_nvm_off_code,
  output logic [1:0][3:0] o_nvm_ov_step,
  output logic [1:0][3:0] o_ov_step,
  output logic [1:0][19:0] o_page_off_sum,
  output ocol_ov_stat_s [1:0] o_ov_stat,
  output logic o_cml_inv_data,
  output logic [1:0] o_output_off,
  output logic o_alert_n
);
  localparam int PHW = (NPH > 1) ? $clog2(NPH) : 1;

  // Offset word to signed amperes with 8 fraction bits
  function automatic logic signed [39:0] dec_fx(input logic [15:0] w);
    logic signed [39:0] m;
    int sh;
    m = 40'(signed'(w[10:0]));
    sh = int'(signed'(w[15:11])) + `OCOL_FRAC;
    if (sh >= 0) dec_fx = m <<< sh;
    else dec_fx = m >>> (-sh);
  endfunction : dec_fx

  function automatic logic [5:0] quant(input logic signed [19:0] fx);
    logic signed [19:0] t;
    t = (fx + `OCOL_Q_HALF) >>> `OCOL_Q_SH;
    quant = t[5:0];
  endfunction : quant

  // Stored options use fixed encodings at the lowest code, at minus one code and at zero
  function automatic logic [15:0] enc(input logic [5:0] k);
    if (k == `OCOL_K_M4) enc = `OCOL_ENC_M4;
    else if (k == `OCOL_K_M1) enc = `OCOL_ENC_M1;
    else if (k == `OCOL_K_Z) enc = `OCOL_ENC_Z;
    else enc = {`OCOL_EXP_RST, {5{k[5]}}, k};
  endfunction : enc

  function automatic logic [15:0] step_mv(input logic [3:0] s);
    step_mv = 16'(s) << `OCOL_OV_SH;
  endfunction : step_mv

  logic scl_s1_reg, scl_s2_reg, scl_s3_reg;
  logic sda_s1_reg, sda_s2_reg, sda_s3_reg;
  logic [1:0] ovd_s1_reg, ovd_s2_reg, ovd_s3_reg;
  ocol_link_e st_reg;
  logic [3:0] bit_reg;
  logic [2:0] byte_reg;
  logic [7:0] shift_reg, tx_sh_reg, cmd_reg, lo_reg, tx_hi_reg;
  logic rw_reg, sda_oe_reg, rst_load_reg, cml_reg, alert_n_reg;
  logic [15:0] off_reg [NPH];
  logic [NPH-1:0][5:0] nvm_code_reg;
  logic [1:0][3:0] step_reg, nvm_step_reg;
  logic [1:0][19:0] sum_reg, sum_next;
  ocol_ov_stat_s [1:0] stat_reg;
  logic [1:0] off_out_reg;
  logic [1:0][31:0] hic_reg;

  logic scl_rise, scl_fall, start, stop, wr_go, ack_now, wr_valid;
  logic off_ok, ph_all, ph_one;
  logic [15:0] wr_word, rd_word;
  logic [1:0] ov_ok, pg_sel;
  logic [1:0][15:0] ov_diff;
  logic [1:0] ov_rise;

  assign scl_rise = scl_s2_reg & ~scl_s3_reg;
  assign scl_fall = ~scl_s2_reg & scl_s3_reg;
  assign start = scl_s2_reg & scl_s3_reg & sda_s3_reg & ~sda_s2_reg;
  assign stop = scl_s2_reg & scl_s3_reg & ~sda_s3_reg & sda_s2_reg;
  assign ov_rise = ovd_s2_reg & ~ovd_s3_reg;
  assign wr_word = {shift_reg, lo_reg};
  assign ph_all = (i_phase == `OCOL_PH_ALL_A) || (i_phase == `OCOL_PH_ALL_B);
  assign ph_one = i_phase < 8'(NPH);
  assign off_ok = (dec_fx(wr_word) >= `OCOL_OFF_MIN) && (dec_fx(wr_word) <= `OCOL_OFF_MAX);

  always_comb begin
    for (int p = 0; p < 2; p++) begin
      ov_diff[p] = wr_word - i_vout_cmd[p];
      pg_sel[p] = (i_page == `OCOL_PAGE_ALL) || (i_page == 8'(p));
      ov_ok[p] = (wr_word >= i_vout_cmd[p]) && (ov_diff[p] >= `OCOL_OV_MIN)
                 && (ov_diff[p] <= `OCOL_OV_MAX) && ((ov_diff[p] & `OCOL_OV_LSBM) == 16'h0000);
    end
  end

  // no selected page, or any selected page failing its limit check, refuses the word
  always_comb begin
    wr_valid = 1'b0;
    if (cmd_reg == `OCOL_CMD_OFFCAL) wr_valid = off_ok && (ph_all || ph_one);
    else if (cmd_reg == `OCOL_CMD_OVLIM) wr_valid = (|pg_sel) && ((~pg_sel | ov_ok) == 2'b11);
  end

  always_comb begin
    case (byte_reg)
      3'h0: ack_now = shift_reg[7:1] == DEV_ADDR;
      3'h1: ack_now = (shift_reg == `OCOL_CMD_OFFCAL) || (shift_reg == `OCOL_CMD_OVLIM);
      3'h2: ack_now = 1'b1;
      3'h3: ack_now = wr_valid;
      default: ack_now = 1'b0;
    endcase
  end

  always_comb begin
    rd_word = 16'h0000;
    if (cmd_reg == `OCOL_CMD_OFFCAL) begin
      if (ph_all) rd_word = off_reg[0];
      else if (ph_one) rd_word = off_reg[i_phase[PHW-1:0]];
    end else if (cmd_reg == `OCOL_CMD_OVLIM) begin
      if (i_page == `OCOL_PAGE_ONE) rd_word = i_vout_cmd[1] + step_mv(step_reg[1]);
      else rd_word = i_vout_cmd[0] + step_mv(step_reg[0]);
    end
  end

  assign wr_go = (st_reg == ST_RX) && scl_fall && (bit_reg == 4'h8) && (byte_reg == 3'h3)
                 && !rw_reg;

  // Pins are asynchronous; edges come from the second stage on
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      {scl_s1_reg, scl_s2_reg, scl_s3_reg} <= 3'h7;
      {sda_s1_reg, sda_s2_reg, sda_s3_reg} <= 3'h7;
      ovd_s1_reg <= 2'h0;
      ovd_s2_reg <= 2'h0;
      ovd_s3_reg <= 2'h0;
    end else begin
      {scl_s1_reg, scl_s2_reg, scl_s3_reg} <= {i_scl, scl_s1_reg, scl_s2_reg};
      {sda_s1_reg, sda_s2_reg, sda_s3_reg} <= {i_sda, sda_s1_reg, sda_s2_reg};
      ovd_s1_reg <= i_ov_detect;
      ovd_s2_reg <= ovd_s1_reg;
      ovd_s3_reg <= ovd_s2_reg;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      st_reg <= ST_IDLE;
      bit_reg <= 4'h0;
      byte_reg <= 3'h0;
      shift_reg <= 8'h00;
      tx_sh_reg <= 8'h00;
      tx_hi_reg <= 8'h00;
      cmd_reg <= 8'h00;
      lo_reg <= 8'h00;
      rw_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (stop) begin
      st_reg <= ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else if (start) begin
      st_reg <= ST_RX;
      bit_reg <= 4'h0;
      byte_reg <= 3'h0;
      sda_oe_reg <= 1'b0;
    end else begin
      case (st_reg)
        ST_RX: begin
          if (scl_rise && bit_reg < 4'h8) begin
            shift_reg <= {shift_reg[6:0], sda_s2_reg};
            bit_reg <= bit_reg + 4'h1;
          end else if (scl_fall && bit_reg == 4'h8) begin
            st_reg <= ST_ACK;
            sda_oe_reg <= ack_now;
            if (byte_reg == 3'h0) rw_reg <= shift_reg[0];
            if (byte_reg == 3'h1) cmd_reg <= shift_reg;
            if (byte_reg == 3'h2) lo_reg <= shift_reg;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_reg <= 4'h0;
            if (byte_reg != 3'h7) byte_reg <= byte_reg + 3'h1;
            if (!sda_oe_reg) begin
              st_reg <= ST_IDLE;
              sda_oe_reg <= 1'b0;
            end else if (rw_reg) begin
              // First data bit goes out on the same falling edge
              st_reg <= ST_TX;
              sda_oe_reg <= ~rd_word[7];
              tx_sh_reg <= {rd_word[6:0], 1'b0};
              tx_hi_reg <= rd_word[15:8];
              bit_reg <= 4'h1;
            end else begin
              st_reg <= ST_RX;
              sda_oe_reg <= 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall && bit_reg < 4'h8) begin
            sda_oe_reg <= ~tx_sh_reg[7];
            tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
            bit_reg <= bit_reg + 4'h1;
          end else if (scl_fall) begin
            sda_oe_reg <= 1'b0;
            st_reg <= ST_MACK;
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            st_reg <= sda_s2_reg ? ST_IDLE : ST_TX;
            bit_reg <= 4'h0;
            tx_sh_reg <= tx_hi_reg;
          end
        end
        default: sda_oe_reg <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      for (int i = 0; i < NPH; i++) off_reg[i] <= {`OCOL_EXP_RST, 11'h000};
      rst_load_reg <= 1'b1;
    end else begin
      rst_load_reg <= 1'b0;
      if (rst_load_reg || i_nvm_restore) begin
        for (int i = 0; i < NPH; i++) off_reg[i] <= enc(i_nvm_off_code[i]);
      end else if (wr_go && cmd_reg == `OCOL_CMD_OFFCAL && wr_valid) begin
        for (int i = 0; i < NPH; i++) begin
          if (ph_all || i_phase == 8'(i)) off_reg[i] <= wr_word;
        end
      end
    end
  end

  // step per page survives voltage changes
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      step_reg <= {2{`OCOL_OV_WIDEST}};
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (rst_load_reg || i_nvm_restore) begin
          step_reg[p] <= i_boot_zero[p] ? `OCOL_OV_WIDEST : i_nvm_ov_step[p];
        end else if (wr_go && cmd_reg == `OCOL_CMD_OVLIM && pg_sel[p] && ov_ok[p]) begin
          step_reg[p] <= 4'(ov_diff[p] >> `OCOL_OV_SH);
        end
      end
    end
  end

  // store image keeps only the 0.125 A options
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      nvm_code_reg <= '0;
      nvm_step_reg <= '0;
    end else if (i_nvm_store) begin
      for (int i = 0; i < NPH; i++) nvm_code_reg[i] <= quant(20'(dec_fx(off_reg[i])));
      nvm_step_reg <= step_reg;
    end
  end

  always_comb begin
    for (int p = 0; p < 2; p++) begin
      sum_next[p] = 20'h00000;
      for (int i = 0; i < NPH; i++) begin
        if (i_ph_active[i] && PH_PAGE1[i] == 1'(p)) sum_next[p] += 20'(dec_fx(off_reg[i]));
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) sum_reg <= '0;
    else sum_reg <= sum_next;
  end

  // fault response; unsupported codes act as ignore
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      stat_reg <= '0;
      off_out_reg <= 2'h0;
      hic_reg <= '0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (ov_rise[p]) stat_reg[p] <= 3'h7;
        else if (i_clear_faults) stat_reg[p] <= 3'h0;
        if (i_off_cmd[p]) begin
          off_out_reg[p] <= 1'b0;
          hic_reg[p] <= 32'h0;
        end else if (ov_rise[p] && !off_out_reg[p]
                     && i_ov_cfg[p].ov_response_action == `OCOL_RESP_SHUT) begin
          off_out_reg[p] <= 1'b1;
          hic_reg[p] <= (i_ov_cfg[p].ov_retry_policy == `OCOL_RETRY_HICCUP)
                        ? 32'(HICCUP_CYC) : 32'h0;
        end else if (off_out_reg[p] && hic_reg[p] != 32'h0) begin
          if (hic_reg[p] == 32'h1) off_out_reg[p] <= 1'b0;
          hic_reg[p] <= hic_reg[p] - 32'h1;
        end
      end
    end
  end

  // invalid data flag, set wins over clear
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      cml_reg <= 1'b0;
      alert_n_reg <= 1'b1;
    end else begin
      if (wr_go && !wr_valid) cml_reg <= 1'b1;
      else if (i_clear_faults) cml_reg <= 1'b0;
      alert_n_reg <= ~(cml_reg | (|stat_reg));
    end
  end

  assign o_sda_out = 1'b0;
  assign o_sda_oe = sda_oe_reg;
  assign o_nvm_off_code = nvm_code_reg;
  assign o_nvm_ov_step = nvm_step_reg;
  assign o_ov_step = step_reg;
  assign o_page_off_sum = sum_reg;
  assign o_ov_stat = stat_reg;
  assign o_cml_inv_data = cml_reg;
  assign o_output_off = off_out_reg;
  assign o_alert_n = alert_n_reg;
endmodule : ocol_cmd_core

// >>> hdl/ocol_consts.svh
// Constants for the offset-cal and OV fault limit command block
`ifndef OCOL_CONSTS_SVH
`define OCOL_CONSTS_SVH
`define OCOL_CMD_OFFCAL 8'h39
`define OCOL_CMD_OVLIM 8'h40
`define OCOL_PH_ALL_A 8'h80
`define OCOL_PH_ALL_B 8'hFF
`define OCOL_PAGE_ALL 8'hFF
`define OCOL_PAGE_ONE 8'h01
`define OCOL_EXP_RST 5'b11101
`define OCOL_FRAC 8
`define OCOL_OFF_MIN 40'shFFFFFFFC00
`define OCOL_OFF_MAX 40'sh00000003C0
`define OCOL_Q_HALF 20'sh00010
`define OCOL_Q_SH 5
`define OCOL_K_M4 6'h20
`define OCOL_K_M1 6'h3F
`define OCOL_K_Z 6'h00
`define OCOL_ENC_M4 16'hFEF0
`define OCOL_ENC_M1 16'hFFFF
`define OCOL_ENC_Z 16'hB800
`define OCOL_OV_SH 5
`define OCOL_OV_LSBM 16'h001F
`define OCOL_OV_MIN 16'h0020
`define OCOL_OV_MAX 16'h01C0
`define OCOL_OV_WIDEST 4'hE
`define OCOL_RESP_SHUT 2'b10
`define OCOL_RETRY_HICCUP 3'h7
`define OCOL_HICCUP_US 1000
`endif

// >>> hdl/ocol_pkg.sv
// Types shared by the offset-cal and OV fault limit command block
package ocol_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} ocol_link_e;
  typedef struct packed {
    logic status_byte_ov;
    logic status_word_vout;
    logic ov_fault_status_bit;
  } ocol_ov_stat_s;
  typedef struct packed {
    logic [1:0] ov_response_action;
    logic [2:0] ov_retry_policy;
  } ocol_ov_cfg_s;
endpackage : ocol_pkg

// >>> sim/ocol_host_model.sv
// Host master model driving word commands over the two-wire link
`timescale 1ns/1ns
module ocol_host_model #(
  parameter logic [6:0] ADDR = 7'h4C
) (
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe
);
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  // Long low phase leaves room for the device's synchroniser delay
  task automatic bit_x(input logic b, output logic r);
    #150 o_sda_oe = !b;
    #150 o_scl = 1'b1;
    r = i_sda;
    #100 o_scl = 1'b0;
  endtask : bit_x
  task automatic byte_x(input logic [7:0] d, input logic a_out, output logic [7:0] q,
                        output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
      q[i] = r;
    end
    bit_x(a_out, r);
    ack = !r;
  endtask : byte_x
  task automatic start_c();
    if (!o_scl) begin
      #100 o_sda_oe = 1'b0;
      #100 o_scl = 1'b1;
    end
    #100 o_sda_oe = 1'b1;
    #100 o_scl = 1'b0;
  endtask : start_c
  task automatic stop_c();
    #100 o_sda_oe = 1'b1;
    #100 o_scl = 1'b1;
    #100 o_sda_oe = 1'b0;
    #200;
  endtask : stop_c
  task automatic write_word(input logic [7:0] c, input logic [15:0] d, output logic ok);
    logic [7:0] q;
    logic [3:0] a;
    start_c();
    byte_x({ADDR, 1'b0}, 1'b1, q, a[0]);
    byte_x(c, 1'b1, q, a[1]);
    byte_x(d[7:0], 1'b1, q, a[2]);
    byte_x(d[15:8], 1'b1, q, a[3]);
    stop_c();
    ok = &a;
  endtask : write_word
  // word read, master nacks the high byte
  task automatic read_word(input logic [7:0] c, output logic [15:0] d);
    logic [7:0] q;
    logic a;
    start_c();
    byte_x({ADDR, 1'b0}, 1'b1, q, a);
    byte_x(c, 1'b1, q, a);
    start_c();
    byte_x({ADDR, 1'b1}, 1'b1, q, a);
    byte_x(8'hFF, 1'b0, d[7:0], a);
    byte_x(8'hFF, 1'b1, d[15:8], a);
    stop_c();
  endtask : read_word
endmodule : ocol_host_model

// >>> sim/ocol_cmd_sva.sv
// Port assertions for the offset-cal and OV limit command block
`timescale 1ns/1ns
module ocol_cmd_sva
  import ocol_pkg::*;
#(
  parameter int HICCUP_CYC = 20000
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_scl,
  input wire logic [1:0] i_boot_zero,
  input wire logic [1:0] i_ov_detect,
  input wire ocol_ov_cfg_s [1:0] i_ov_cfg,
  input wire logic i_clear_faults,
  input wire logic [1:0] i_off_cmd,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic [1:0][3:0] o_ov_step,
  input wire ocol_ov_stat_s [1:0] o_ov_stat,
  input wire logic o_cml_inv_data,
  input wire logic [1:0] o_output_off,
  input wire logic o_alert_n
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  logic rel_q;
  logic [15:0] off_cnt;
  // Low on the first edge after reset, so $past never sees pre-reset state
  always_ff @(posedge i_core_clk) begin
    rel_q <= i_resetn;
  end
  always_ff @(posedge i_core_clk) begin
    off_cnt <= o_output_off[0] ? off_cnt + 16'h0001 : 16'h0000;
  end
  a_sda_open_drain: assert property (o_sda_out == 1'b0)
    else $error("data pin driven high");
  a_sda_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data pin changed while clock high");
  a_alert_tracks: assert property (rel_q |->
    o_alert_n == !($past(|o_ov_stat) || $past(o_cml_inv_data)))
    else $error("alert does not follow flags");
  a_stat_sticky: assert property (rel_q && !$past(i_clear_faults) |->
    (o_ov_stat & $past(o_ov_stat)) == $past(o_ov_stat))
    else $error("status bit dropped without clear");
  a_inv_sticky: assert property (rel_q && $fell(o_cml_inv_data) |-> $past(i_clear_faults))
    else $error("invalid data flag dropped without clear");
  a_ov_sets_stat: assert property ($rose(i_ov_detect[0]) |-> ##[2:6] o_ov_stat[0] == 3'b111)
    else $error("fault did not set status bits");
  a_boot_widest: assert property (i_resetn && !rel_q && i_boot_zero[1] |=>
    o_ov_step[1] == 4'hE)
    else $error("zero boot voltage did not force widest step");
  a_step_legal: assert property (!(o_ov_step[0] inside {4'h0, 4'hF}))
    else $error("unsupported step selected");
  a_shut_cause: assert property ($rose(o_output_off[0]) |->
    $past(i_ov_cfg[0].ov_response_action) == 2'b10)
    else $error("shutdown without shutdown response");
  a_hiccup_len: assert property (rel_q && $fell(o_output_off[0]) && !$past(i_off_cmd[0])
    && i_ov_cfg[0].ov_retry_policy == 3'h7 |-> off_cnt == 16'(HICCUP_CYC))
    else $error("hiccup length wrong");
  a_latch_off: assert property (o_output_off[1] && i_ov_cfg[1].ov_retry_policy == 3'h0
    && !i_off_cmd[1] |=> o_output_off[1])
    else $error("latched shutdown released");
endmodule : ocol_cmd_sva
bind ocol_cmd_core ocol_cmd_sva #(.HICCUP_CYC(HICCUP_CYC)) u_ocol_cmd_sva (
  .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_scl(i_scl), .i_boot_zero(i_boot_zero),
  .i_ov_detect(i_ov_detect), .i_ov_cfg(i_ov_cfg), .i_clear_faults(i_clear_faults),
  .i_off_cmd(i_off_cmd), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_ov_step(o_ov_step),
  .o_ov_stat(o_ov_stat), .o_cml_inv_data(o_cml_inv_data), .o_output_off(o_output_off),
  .o_alert_n(o_alert_n));

// >>> sim/testbench.sv
// Self-checking bench for the offset-cal and OV limit command block
`timescale 1ns/1ns
module testbench;
  import ocol_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] page = 8'h00;
  logic [7:0] phase = 8'h00;
  logic [1:0][15:0] vout = {16'h07D0, 16'h03E8};
  logic [1:0] bootz = 2'b10;
  logic [3:0] act = 4'hF;
  logic store = 1'b0;
  logic restore = 1'b0;
  logic [3:0][5:0] nk = {6'h03, 6'h00, 6'h3F, 6'h20};
  logic [1:0][3:0] ns = {4'h1, 4'h2};
  logic [1:0] ovd = 2'b00;
  ocol_ov_cfg_s [1:0] cfg = {5'b10000, 5'b10111};
  logic clr = 1'b0;
  logic [1:0] offc = 2'b00;
  logic scl, hoe, oe, sout, inv, alert_n, ok;
  logic [3:0][5:0] nk_img;
  logic [1:0][3:0] st_img, step;
  logic [1:0][19:0] sum;
  ocol_ov_stat_s [1:0] stat;
  logic [1:0] off;
  logic [15:0] rv, last;
  logic [3:0] ls = 4'h2;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  logic [15:0] rst_enc [4] = '{16'hFEF0, 16'hFFFF, 16'hB800, 16'hE803};
  logic [15:0] ow [5] = '{16'hE81E, 16'hE81F, 16'hEFE0, 16'hEFDF, 16'hE001};
  logic [4:0] okw = 5'b10101;
  logic [8:0] lo [6] = '{9'd16, 9'd32, 9'd40, 9'd448, 9'd480, 9'd128};
  logic [5:0] lok = 6'b101010;
  // Pull-up on the data wire
  wire sda = hoe ? 1'b0 : (oe ? sout : 1'b1);
  always #25 clk = !clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      finish_test();
    end
  end
  ocol_host_model u_ocol_host_model (.i_sda(sda), .o_scl(scl), .o_sda_oe(hoe));
  ocol_cmd_core #(.HICCUP_CYC(8)) u_ocol_cmd_core (
    .i_core_clk(clk), .i_resetn(rstn), .i_scl(scl), .i_sda(sda), .o_sda_out(sout),
    .o_sda_oe(oe), .i_page(page), .i_phase(phase), .i_vout_cmd(vout), .i_boot_zero(bootz),
    .i_ph_active(act), .i_nvm_store(store), .i_nvm_restore(restore), .i_nvm_off_code(nk),
    .i_nvm_ov_step(ns), .i_ov_detect(ovd), .i_ov_cfg(cfg), .i_clear_faults(clr),
    .i_off_cmd(offc), .o_nvm_off_code(nk_img), .o_nvm_ov_step(st_img), .o_ov_step(step),
    .o_page_off_sum(sum), .o_ov_stat(stat), .o_cml_inv_data(inv), .o_output_off(off),
    .o_alert_n(alert_n));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic e);
    u_ocol_host_model.write_word(c, d, ok);
    tick(1);
    chk(20'(ok), 20'(e));
  endtask : wr
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    u_ocol_host_model.read_word(c, rv);
    tick(1);
    chk(20'(rv), 20'(e));
  endtask : rd
  // Mask bits: off commands, restore, store, clear; no ref to a vector bit
  task automatic pulse(input logic [4:0] m);
    {offc, restore, store, clr} = m;
    tick(1);
    {offc, restore, store, clr} = 5'h00;
    tick(2);
  endtask : pulse
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  initial begin
    tick(4);
    rstn = 1'b1;
    tick(4);
    for (int p = 0; p < 4; p++) begin
      page = (p > 1) ? 8'h01 : 8'h00;
      phase = 8'(p);
      rd(8'h39, rst_enc[p]);
    end
    page = 8'h00;
    chk(20'(step), 20'h0E2);
    chk(sum[1], 20'h00060);
    $display("test reset done");
    phase = 8'h80;
    wr(8'h39, 16'hE804, 1'b1);
    phase = 8'h00;
    wr(8'h39, 16'hE808, 1'b1);
    phase = 8'hFF;
    rd(8'h39, 16'hE808);
    phase = 8'h01;
    rd(8'h39, 16'hE804);
    chk(sum[0], 20'h00180);
    chk(sum[1], 20'h00100);
    act = 4'hD;
    tick(3);
    chk(sum[0], 20'h00100);
    act = 4'hF;
    $display("test phase done");
    for (int i = 0; i < 5; i++) begin
      wr(8'h39, ow[i], okw[i]);
      if (okw[i]) last = ow[i];
      rd(8'h39, last);
    end
    chk(20'(inv), 20'h1);
    chk(20'(alert_n), 20'h0);
    pulse(5'h01);
    chk(20'(inv), 20'h0);
    chk(20'(alert_n), 20'h1);
    $display("test range done");
    for (int i = 0; i < 6; i++) begin
      wr(8'h40, 16'h03E8 + 16'(lo[i]), lok[i]);
      if (lok[i]) ls = lo[i][8:5];
      chk(20'(step[0]), 20'(ls));
    end
    rd(8'h40, 16'h0468);
    vout[0] = 16'h044C;
    rd(8'h40, 16'h04CC);
    chk(20'(step[0]), 20'h4);
    page = 8'h01;
    rd(8'h40, 16'h0990);
    page = 8'hFF;
    vout[0] = 16'h03E8;
    wr(8'h40, 16'h0428, 1'b0);
    chk(20'(step), 20'h0E2);
    page = 8'h00;
    pulse(5'h01);
    $display("test limit done");
    pulse(5'h02);
    chk(20'(nk_img[1]), 20'h01);
    chk(20'(nk_img[0]), 20'h08);
    chk(20'(st_img[0]), 20'h2);
    nk[1] = 6'h00;
    pulse(5'h04);
    rd(8'h39, 16'hB800);
    phase = 8'h00;
    rd(8'h39, 16'hFEF0);
    $display("test store done");
    ovd = 2'b11;
    tick(6);
    chk(20'(stat), 20'h3F);
    chk(20'(off), 20'h3);
    ovd = 2'b00;
    tick(10);
    chk(20'(off), 20'h2);
    pulse(5'h10);
    chk(20'(off), 20'h0);
    cfg[0].ov_response_action = 2'b00;
    // Unsupported response code must act as ignore
    cfg[1].ov_response_action = 2'b11;
    pulse(5'h01);
    ovd = 2'b11;
    tick(6);
    chk(20'(off), 20'h0);
    chk(20'(stat[0]), 20'h7);
    chk(20'(stat[1]), 20'h7);
    $display("test fault done");
    finish_test();
  end
endmodule : testbench
